// *** pcm_pkg.sv ***
// Constants shared by the press cam monitor files
package pcm_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 40;
  localparam logic [31:0] CYC_PER_MS    = 32'(1000000 / CLK_PERIOD_NS);
  localparam int          POS_W         = 32;
  localparam int          TIME_W        = 16;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_PARAM0    = 8'h08;
  localparam int         NPARAM        = 13;
  // Parameter indices, each one word after OFS_PARAM0
  localparam int P_JITTER      = 0;
  localparam int P_STILL_MS    = 1;
  localparam int P_START_MS    = 2;
  localparam int P_MOTION_MS   = 3;
  localparam int P_MIN_DELTA   = 4;
  localparam int P_FULL_LIMIT  = 5;
  localparam int P_TOP_LOW     = 6;
  localparam int P_TOP_HIGH    = 7;
  localparam int P_TOP2_LOW    = 8;
  localparam int P_TOP2_HIGH   = 9;
  localparam int P_BOT_LOW     = 10;
  localparam int P_BOT_HIGH    = 11;
  localparam int P_STOP_LIMIT  = 12;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_PENDULUM = 0;
  localparam int CTRL_EXCENTRIC = 1;
  localparam int CTRL_CAMS_EN  = 2;
  localparam int CTRL_W        = 3;
  localparam int PIN_AUTO      = 0;
  localparam int PIN_SETUP     = 1;
  localparam int PIN_RESET     = 2;
  localparam int PIN_CMD       = 3;
  localparam int PIN_REVERSE   = 4;
  localparam int PIN_STOP_CAM  = 5;
  localparam int PIN_RISE_CAM  = 6;
  localparam int PIN_W         = 7;
  localparam int NFAULT        = 7;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST  = 3'h2;
  localparam logic [31:0]       PARAM_RST = 32'h0;
endpackage

// *** pcm_span_meter.sv ***
// Position span meter over a repeating time window
module pcm_span_meter
#(
  parameter int PW = 32
)
(
  input  wire logic          ref_clk,
  input  wire logic          srst,
  input  wire logic          restart,
  input  wire logic [PW-1:0] pos,
  input  wire logic [31:0]   win_cycles,
  output logic               done,
  output logic [PW-1:0]      span
);
  import pcm_pkg::*;

  typedef struct packed {
    logic [31:0]   cnt;
    logic [PW-1:0] lo;
    logic [PW-1:0] hi;
    logic          done;
    logic [PW-1:0] span;
  } pcm_span_st_t;

  pcm_span_st_t r;
  pcm_span_st_t nxt;

  // ----------------------------------------------------------------
  // Window bookkeeping
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt = r;
    nxt.done = 1'b0;
    if (restart)
    begin
      nxt.cnt = 32'h0;
      nxt.lo = pos;
      nxt.hi = pos;
    end
    else if (r.cnt + 32'h1 >= win_cycles)
    begin
      // Span includes the sample of the closing cycle
      nxt.done = 1'b1;
      nxt.span = ((pos > r.hi) ? pos : r.hi) - ((pos < r.lo) ? pos : r.lo);
      nxt.cnt = 32'h0;
      nxt.lo = pos;
      nxt.hi = pos;
    end
    else
    begin
      nxt.cnt = r.cnt + 32'h1;
      if (pos < r.lo)
        nxt.lo = pos;
      if (pos > r.hi)
        nxt.hi = pos;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      r <= '0;
    else
      r <= nxt;
  end

  assign done = r.done;
  assign span = r.span;
endmodule

// *** pcm_press_cam_monitor.sv ***
// Press cam monitor top: checks, outputs and Avalon-MM register slave
//
// Functional notes
// - Automatic input 0 runs parameter verification; 1 skips it.
// - Parameters change only while setup input is 1.
// - Motion or leaving top window only after a falling reset edge.
// - Motion command 1 expects position change using delay, window, delta.
// - Standstill judged over a time window within the jitter band.
// - Rising motion command starts start-delay interval; motion must come.
// - After first motion, position must keep changing each motion window.
// - Motion counts only when change reaches minimum delta in window.
// - Full-turn limit is the largest permitted position.
// - Pendulum and excentric modes, each by its own flag.
// - Excentric with cams: rising cam on after bottom, off at zero.
// - Stop cam on after top-low, held at standstill, drops at next start.
// - Reverse allowed only with both cams off; ends at stop cam.
// - Excentric reverse ends at upper top window limit.
// - Excentric: passing stop limit without standstill clears monitor ok.
// - Excentric uses one top window low-left, high-right; second ignored.
// - Upward output set leaving bottom window, cleared on standstill.
// - Standstill when window span is at most the jitter band.
// - Start delay expiring with command and no motion clears monitor ok.
// - Monitor ok set while checks pass; first set on falling reset.
// - Top flag when position lies within the top window.
module pcm_press_cam_monitor
(
  input  wire logic                      ref_clk,
  input  wire logic                      srst,
  input  wire logic [7:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic [pcm_pkg::POS_W-1:0] position_in,
  input  wire logic                      automatic_in,
  input  wire logic                      param_setup_enable,
  input  wire logic                      start_release_reset,
  input  wire logic                      motion_commanded_in,
  input  wire logic                      reverse_permit,
  input  wire logic                      stop_cam_in,
  input  wire logic                      rising_cam_in,
  output logic                           monitor_ok,
  output logic                           top_dead_centre_flag,
  output logic                           bottom_dead_centre_flag,
  output logic                           upward_move_flag,
  output logic                           reverse_allowed
);
  import pcm_pkg::*;

  typedef struct packed {
    logic [PIN_W-1:0]              pin_s1;
    logic [PIN_W-1:0]              pin_s2;
    logic [POS_W-1:0]              pos_s1;
    logic [POS_W-1:0]              pos_s2;
    logic                          reset_d;
    logic                          cmd_d;
    logic                          bot_d;
    logic                          armed;
    logic                          ok;
    logic                          still;
    logic                          moving;
    logic                          motion_seen;
    logic [31:0]                   start_cnt;
    logic                          start_run;
    logic                          upward;
    logic                          top;
    logic                          bot;
    logic                          rev;
    logic                          stop_held;
    logic [NFAULT-1:0]             fault;
    logic [CTRL_W-1:0]             ctrl;
    logic [NPARAM-1:0][31:0]       prm;
    logic                          wait_r;
    logic [31:0]                   rdata;
  } pcm_state_t;

  pcm_state_t r;
  pcm_state_t nxt;

  // Synchronised views
  logic [POS_W-1:0] pos;
  logic             p_auto;
  logic             p_setup;
  logic             p_reset;
  logic             p_cmd;
  logic             p_rev;
  logic             p_stop;
  logic             p_rise;
  logic             excentric;
  logic             pendulum;
  logic             cams_en;
  logic [POS_W-1:0] half_turn;
  logic             still_done;
  logic [POS_W-1:0] still_span;
  logic             motion_done;
  logic [POS_W-1:0] motion_span;
  logic             cmd_rise;
  logic             cmd_fall;
  logic             reset_fall;

  assign pos       = r.pos_s2;
  assign p_auto    = r.pin_s2[PIN_AUTO];
  assign p_setup   = r.pin_s2[PIN_SETUP];
  assign p_reset   = r.pin_s2[PIN_RESET];
  assign p_cmd     = r.pin_s2[PIN_CMD];
  assign p_rev     = r.pin_s2[PIN_REVERSE];
  assign p_stop    = r.pin_s2[PIN_STOP_CAM];
  assign p_rise    = r.pin_s2[PIN_RISE_CAM];
  assign excentric = r.ctrl[CTRL_EXCENTRIC];
  assign pendulum  = r.ctrl[CTRL_PENDULUM];
  assign cams_en   = r.ctrl[CTRL_CAMS_EN];
  assign half_turn = r.prm[P_FULL_LIMIT] >> 1;
  assign cmd_rise  = p_cmd & ~r.cmd_d;
  assign cmd_fall  = ~p_cmd & r.cmd_d;
  assign reset_fall = ~p_reset & r.reset_d;

  function automatic logic [31:0] ms_to_cyc(input logic [31:0] ms);
    logic [31:0] c;
    c = 32'(ms[TIME_W-1:0]) * CYC_PER_MS;
    return (c == 32'h0) ? 32'h1 : c;
  endfunction

  function automatic logic [31:0] lane_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // ----------------------------------------------------------------
  // Standstill and motion windows
  // ----------------------------------------------------------------
  pcm_span_meter
  #(
    .PW (POS_W)
  )
  u_still
  (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .restart    (cmd_fall),
    .pos        (pos),
    .win_cycles (ms_to_cyc(r.prm[P_STILL_MS])),
    .done       (still_done),
    .span       (still_span)
  );

  pcm_span_meter
  #(
    .PW (POS_W)
  )
  u_motion
  (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .restart    (cmd_rise),
    .pos        (pos),
    .win_cycles (ms_to_cyc(r.prm[P_MOTION_MS])),
    .done       (motion_done),
    .span       (motion_span)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic              top_now;
  logic              bot_now;
  logic              cfg_bad;
  logic [NFAULT-1:0] fault_now;
  logic              start_exp;

  always_comb
  begin
    // Excentric top window wraps through zero: low left, high right
    if (excentric)
      top_now = (pos >= r.prm[P_TOP_LOW]) | (pos <= r.prm[P_TOP_HIGH]);
    else
      top_now = ((pos >= r.prm[P_TOP_LOW]) & (pos <= r.prm[P_TOP_HIGH]))
              | ((pos >= r.prm[P_TOP2_HIGH]) & (pos <= r.prm[P_TOP2_LOW]));
    bot_now = (pos >= r.prm[P_BOT_LOW]) & (pos <= r.prm[P_BOT_HIGH]);
    // Configuration the far side promised to respect
    cfg_bad = (pendulum == excentric);
    if (excentric)
    begin
      cfg_bad = cfg_bad
              | (r.prm[P_STOP_LIMIT] <= r.prm[P_TOP_HIGH])
              | (r.prm[P_STOP_LIMIT] >= r.prm[P_BOT_LOW])
              | (r.prm[P_BOT_LOW] >= half_turn)
              | (r.prm[P_BOT_HIGH] <= half_turn)
              | (r.prm[P_BOT_HIGH] >= r.prm[P_TOP_LOW]);
    end
    cfg_bad = cfg_bad | (r.prm[P_TOP_LOW] > r.prm[P_FULL_LIMIT]);
    start_exp = r.start_run & (r.start_cnt == 32'h0);
    fault_now = '0;
    fault_now[0] = ~p_auto & cfg_bad;
    fault_now[1] = pos > r.prm[P_FULL_LIMIT];
    fault_now[2] = start_exp & p_cmd & ~r.motion_seen;
    // Motion once seen must keep up each window
    fault_now[3] = p_cmd & r.motion_seen & motion_done
                 & (motion_span < r.prm[P_MIN_DELTA]);
    // Commanded motion or a top exit without release; coasting to a stop is no fault
    fault_now[4] = ~r.armed & ((p_cmd & r.moving & ~r.still) | (r.top & ~top_now));
    fault_now[5] = excentric & cams_en
                 & ((p_rise & r.top & ~top_now & ~r.bot)
                 | (~p_rise & r.upward & (pos > r.prm[P_BOT_HIGH])
                    & (pos < r.prm[P_TOP_LOW]))
                 | (r.stop_held & ~p_stop & ~p_cmd));
    fault_now[6] = excentric & ~p_cmd & ~r.still
                 & (pos > r.prm[P_STOP_LIMIT]) & (pos < r.prm[P_BOT_LOW]);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [5:0] widx;
  logic       hit;

  always_comb
  begin
    nxt = r;
    widx = 6'(avs_address[7:2] - OFS_PARAM0[7:2]);
    hit = 1'b0;
    nxt.pin_s1 = {rising_cam_in, stop_cam_in, reverse_permit, motion_commanded_in,
                  start_release_reset, param_setup_enable, automatic_in};
    nxt.pin_s2 = r.pin_s1;
    nxt.pos_s1 = position_in;
    nxt.pos_s2 = r.pos_s1;
    nxt.reset_d = p_reset;
    nxt.cmd_d = p_cmd;
    nxt.bot_d = bot_now;
    nxt.top = top_now;
    nxt.bot = bot_now;

    // Standstill over a time window
    if (still_done)
      nxt.still = (still_span <= r.prm[P_JITTER]);

    // Motion presence
    if (cmd_rise)
    begin
      nxt.moving = 1'b0;
      nxt.motion_seen = 1'b0;
    end
    else if (p_cmd & motion_done)
    begin
      nxt.moving = (motion_span >= r.prm[P_MIN_DELTA]);
      if (motion_span >= r.prm[P_MIN_DELTA])
        nxt.motion_seen = 1'b1;
    end
    if (~p_cmd & still_done & (still_span <= r.prm[P_JITTER]))
      nxt.moving = 1'b0;

    // Start delay counted in cycles from the rising command
    if (cmd_rise)
    begin
      nxt.start_cnt = ms_to_cyc(r.prm[P_START_MS]);
      nxt.start_run = 1'b1;
    end
    else if (start_exp | ~p_cmd)
      nxt.start_run = 1'b0;
    else if (r.start_run)
      nxt.start_cnt = r.start_cnt - 32'h1;

    // Release: falling reset arms one start, a stop disarms
    if (reset_fall)
      nxt.armed = 1'b1;
    else if (cmd_fall)
      nxt.armed = 1'b0;

    // Upward leg
    if (r.bot_d & ~bot_now & r.moving)
      nxt.upward = 1'b1;
    else if (still_done & (still_span <= r.prm[P_JITTER]))
      nxt.upward = 1'b0;

    // Stop cam must hold once seen past the top-low limit
    if (cmd_rise)
      nxt.stop_held = 1'b0;
    else if (excentric & cams_en & p_stop & (pos >= r.prm[P_TOP_LOW]))
      nxt.stop_held = 1'b1;

    // Reverse run: both cams idle and, in excentric mode only, not yet at the top-high limit
    nxt.rev = p_rev & ~p_rise & ~p_stop
            & ~(excentric & (pos <= r.prm[P_TOP_HIGH]));

    // Faults stick until the next release; a fault in the release
    // cycle keeps ok low rather than being lost
    if (reset_fall)
    begin
      nxt.fault = fault_now;
      nxt.ok = (fault_now == '0);
    end
    else
    begin
      nxt.fault = r.fault | fault_now;
      if (fault_now != '0)
        nxt.ok = 1'b0;
    end

    // Avalon-MM slave: one wait cycle, then answer
    nxt.wait_r = 1'b1;
    if ((avs_read | avs_write) & r.wait_r)
    begin
      nxt.wait_r = 1'b0;
      nxt.rdata = 32'h0;
      if (avs_address == OFS_CTRL)
        nxt.rdata = 32'(r.ctrl);
      else if (avs_address == OFS_STATUS)
        nxt.rdata = {18'h0, r.fault, r.armed, r.moving, r.still, r.upward,
                     r.top, r.ok, p_setup};
      else if ((avs_address >= OFS_PARAM0) & (widx < 6'(NPARAM)))
        nxt.rdata = r.prm[widx];
    end
    if (avs_write & ~r.wait_r & p_setup)
    begin
      if (avs_address == OFS_CTRL)
        nxt.ctrl = CTRL_W'(lane_merge(32'(r.ctrl), avs_writedata, avs_byteenable));
      else if ((avs_address >= OFS_PARAM0) & (widx < 6'(NPARAM)))
        hit = 1'b1;
      if (hit)
        nxt.prm[widx] = lane_merge(r.prm[widx], avs_writedata, avs_byteenable);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      r <= '0;
      r.ctrl <= CTRL_RST;
      r.prm <= {NPARAM{PARAM_RST}};
      r.wait_r <= 1'b1;
    end
    else
    begin
      r <= nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata            = r.rdata;
  assign avs_waitrequest         = r.wait_r;
  assign monitor_ok              = r.ok;
  assign top_dead_centre_flag    = r.top;
  assign bottom_dead_centre_flag = r.bot;
  assign upward_move_flag        = r.upward;
  assign reverse_allowed         = r.rev;
endmodule

// *** pcm_press_model.sv ***
// Press position encoder and hardware cam switch model
module pcm_press_model
#(
  parameter logic [31:0] TOP_LOW  = 32'h0,
  parameter logic [31:0] BOT_HIGH = 32'h0
)
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [31:0] set_pos,
  input  wire logic        load,
  input  wire logic        ramp_en,
  input  wire logic        motion_cmd,
  output logic      [31:0] position_in,
  output logic             stop_cam_in,
  output logic             rising_cam_in
);
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed
  {
    logic [31:0] pos;
    logic        stop_cam;
    logic        cmd_d;
  } pcm_model_t;
  pcm_model_t st_r;
  pcm_model_t st_nxt;
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.cmd_d = motion_cmd;
    if (load)
      st_nxt.pos = set_pos;
    else if (ramp_en)
      st_nxt.pos = st_r.pos + 32'h1;
    // Held through standstill; only the next start may drop it
    if (motion_cmd && !st_r.cmd_d)
      st_nxt.stop_cam = 1'b0;
    else if (st_r.pos >= TOP_LOW)
      st_nxt.stop_cam = 1'b1;
  end
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign position_in = st_r.pos;
  assign stop_cam_in = st_r.stop_cam;
  // On past the bottom window, off once the turn wraps back to zero
  assign rising_cam_in = (st_r.pos > BOT_HIGH);
endmodule

// *** pcm_press_cam_monitor_asserts.sv ***
// Port-level assertions for the press cam monitor
module pcm_press_cam_monitor_chk
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic start_release_reset,
  input wire logic reverse_permit,
  input wire logic stop_cam_in,
  input wire logic rising_cam_in,
  input wire logic monitor_ok,
  input wire logic bottom_dead_centre_flag,
  input wire logic upward_move_flag,
  input wire logic reverse_allowed
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] fall_age_r;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // ------
  // Helper
  // ------
  // Saturates so a stale release edge cannot excuse a late rise of ok
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      fall_age_r <= 4'hf;
    else if ($fell(start_release_reset))
      fall_age_r <= 4'h0;
    else if (fall_age_r != 4'hf)
      fall_age_r <= fall_age_r + 4'h1;
  end
  // ------
  // Checks
  // ------
  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one cycle");
  bus_single_a: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  bus_idle_a: assert property (
    !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without a request");
  reset_out_a: assert property (
    $past(srst) |-> !monitor_ok && !upward_move_flag && !reverse_allowed && avs_waitrequest)
    else $error("outputs not at reset values");
  ok_release_a: assert property (
    $rose(monitor_ok) |-> fall_age_r <= 4'h6)
    else $error("monitor ok rose without a release fall");
  up_leave_a: assert property (
    $rose(upward_move_flag) |->
      $past(bottom_dead_centre_flag) || $past(bottom_dead_centre_flag, 2))
    else $error("upward flag set away from the bottom window");
  rev_cams_a: assert property (
    reverse_allowed |-> !$past(stop_cam_in, 3) && !$past(rising_cam_in, 3))
    else $error("reverse allowed with a cam active");
  rev_permit_a: assert property (
    reverse_allowed |-> $past(reverse_permit, 3))
    else $error("reverse allowed without permit");
endmodule

bind pcm_press_cam_monitor pcm_press_cam_monitor_chk pcm_chk_i
(
  .ref_clk, .srst, .avs_read, .avs_write, .avs_waitrequest, .start_release_reset,
  .reverse_permit, .stop_cam_in, .rising_cam_in, .monitor_ok, .bottom_dead_centre_flag,
  .upward_move_flag, .reverse_allowed
);

// *** tb_top.sv ***
// Self-checking bench for the press cam monitor
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pcm_pkg::*;
  // Valid excentric layout: stop limit between top-high and bottom-low,
  // bottom window straddling half the full turn
  localparam logic [31:0] PARAMS [NPARAM] = '{32'h4, 32'h1, 32'h2, 32'h1, 32'ha,
    32'hfde8, 32'hfc17, 32'h64, 32'h4e20, 32'h5208, 32'h7c17, 32'h83e7, 32'h7d0};
  localparam logic [31:0] ROW_POS [10] = '{32'h0, 32'h64, 32'h65, 32'h5014, 32'h7c16,
    32'h7c17, 32'h83e7, 32'h83e8, 32'hfc16, 32'hfc17};
  localparam logic [1:0]  ROW_FLAGS [10] = '{2'h2, 2'h2, 2'h0, 2'h0, 2'h0,
    2'h1, 2'h1, 2'h0, 2'h0, 2'h2};
  logic        ref_clk = 1'b0, srst = 1'b1;
  logic [7:0]  avs_address = 8'h0;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_q, position_in;
  logic [31:0] set_pos = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        avs_waitrequest, stop_cam_in, rising_cam_in, load = 1'b0, ramp_en = 1'b0;
  logic        automatic_in = 1'b0, param_setup_enable = 1'b0, start_release_reset = 1'b0;
  logic        motion_commanded_in = 1'b0, reverse_permit = 1'b0;
  logic        monitor_ok, top_dead_centre_flag, bottom_dead_centre_flag;
  logic        upward_move_flag, reverse_allowed;
  int          mismatches = 0, n_tests = 0;

  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

  pcm_press_cam_monitor pcm_press_cam_monitor_i
  (
    .ref_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .position_in, .automatic_in, .param_setup_enable,
    .start_release_reset, .motion_commanded_in, .reverse_permit, .stop_cam_in,
    .rising_cam_in, .monitor_ok, .top_dead_centre_flag, .bottom_dead_centre_flag,
    .upward_move_flag, .reverse_allowed
  );
  pcm_press_model #(.TOP_LOW(PARAMS[P_TOP_LOW]), .BOT_HIGH(PARAMS[P_BOT_HIGH])) pcm_press_model_i
  (
    .ref_clk, .srst, .set_pos, .load, .ramp_en, .motion_cmd(motion_commanded_in),
    .position_in, .stop_cam_in, .rising_cam_in
  );
  // ------
  // Tasks
  // ------
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Entered just after an edge; holds the request until waitrequest is seen low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
      @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0);
    rd_q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    cyc(1);
  endtask
  task mv(input logic [31:0] p);
    set_pos <= p;
    load <= 1'b1;
    cyc(1);
    load <= 1'b0;
    cyc(5);
  endtask
  task rel();
    start_release_reset <= 1'b1;
    cyc(4);
    start_release_reset <= 1'b0;
    cyc(6);
  endtask
  task print_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ------
  // Sequence
  // ------
  initial
  begin
    int k;
    cyc(6);
    srst <= 1'b0;
    cyc(1);
    bus(1'b1, OFS_PARAM0, 32'h7);
    for (k = 0; k < NPARAM; k++)
      bus(1'b1, OFS_PARAM0 + 8'(4 * k), PARAMS[k]);
    param_setup_enable <= 1'b1;
    cyc(4);
    for (k = 0; k < NPARAM; k++)
      bus(1'b1, OFS_PARAM0 + 8'(4 * k), PARAMS[k]);
    param_setup_enable <= 1'b0;
    cyc(4);
    bus(1'b1, OFS_PARAM0, 32'h7);
    bus(1'b0, OFS_PARAM0, 32'h0);
    chk_word(rd_q, PARAMS[P_JITTER]);
    for (k = 0; k < 10; k++)
    begin
      mv(ROW_POS[k]);
      chk_bit(top_dead_centre_flag, ROW_FLAGS[k][1]);
      chk_bit(bottom_dead_centre_flag, ROW_FLAGS[k][0]);
    end
    bus(1'b0, OFS_CTRL, 32'h0);
    chk_word(rd_q, {29'h0, CTRL_RST});
    bus(1'b0, 8'h3c, 32'h0);
    chk_word(rd_q, 32'h0);
    mv(32'hfa00);
    rel();
    chk_bit(monitor_ok, 1'b1);
    mv(32'hffff);
    chk_bit(monitor_ok, 1'b0);
    reverse_permit <= 1'b1;
    cyc(5);
    chk_bit(reverse_allowed, 1'b0);
    reverse_permit <= 1'b0;
    // A stop limit above bottom-low breaks the layout; only automatic mode tolerates it
    // A high limit keeps the overrun check quiet near zero; cams are checked from here
    param_setup_enable <= 1'b1;
    cyc(4);
    bus(1'b1, OFS_CTRL, 32'((1 << CTRL_EXCENTRIC) | (1 << CTRL_CAMS_EN)));
    bus(1'b0, OFS_CTRL, 32'h0);
    chk_word(rd_q, 32'((1 << CTRL_EXCENTRIC) | (1 << CTRL_CAMS_EN)));
    bus(1'b1, OFS_PARAM0 + 8'(4 * P_STOP_LIMIT), 32'h8000);
    mv(32'h64);
    rel();
    chk_bit(monitor_ok, 1'b0);
    automatic_in <= 1'b1;
    cyc(4);
    rel();
    chk_bit(monitor_ok, 1'b1);
    automatic_in <= 1'b0;
    cyc(6);
    chk_bit(monitor_ok, 1'b0);
    bus(1'b1, OFS_PARAM0 + 8'(4 * P_STOP_LIMIT), PARAMS[P_STOP_LIMIT]);
    param_setup_enable <= 1'b0;
    cyc(4);
    rel();
    chk_bit(monitor_ok, 1'b1);
    motion_commanded_in <= 1'b1;
    ramp_en <= 1'b1;
    for (k = 0; k < 40000 && upward_move_flag !== 1'b1; k++)
      cyc(1);
    chk_bit(upward_move_flag, 1'b1);
    chk_bit(bottom_dead_centre_flag, 1'b0);
    motion_commanded_in <= 1'b0;
    ramp_en <= 1'b0;
    for (k = 0; k < 30000 && upward_move_flag !== 1'b0; k++)
      cyc(1);
    chk_bit(upward_move_flag, 1'b0);
    chk_bit(monitor_ok, 1'b1);
    // Clean stroke: only ok and standstill remain set in the status word
    bus(1'b0, OFS_STATUS, 32'h0);
    chk_word(rd_q, 32'h12);
    mv(32'h3e80);
    rel();
    reverse_permit <= 1'b1;
    cyc(5);
    chk_bit(reverse_allowed, 1'b1);
    mv(32'h32);
    chk_bit(reverse_allowed, 1'b0);
    print_verdict();
  end

  initial
  begin
    repeat (90000) @(posedge ref_clk);
    mismatches++;
    print_verdict();
  end
endmodule
